// ==== hw/eeprom_cmd_pkg.sv ====
// Constants and types for the scratchpad memory command block
package eeprom_cmd_pkg;
  localparam logic [7:0]  CMD_WRITE_SP   = 8'h0F;
  localparam logic [7:0]  CMD_READ_SP    = 8'hAA;
  localparam logic [7:0]  CMD_COPY_SP    = 8'h55;
  localparam logic [7:0]  CMD_READ_MEM   = 8'hF0;
  localparam logic [7:0]  PROT_WRITE     = 8'h55;
  localparam logic [7:0]  PROT_EPROM     = 8'hAA;
  localparam logic [7:0]  FACTORY_LOCK   = 8'hAA;
  localparam logic [7:0]  ADDR_PROT_BASE = 8'h80;
  localparam logic [7:0]  ADDR_COPY_PROT = 8'h84;
  localparam logic [7:0]  ADDR_FACTORY   = 8'h85;
  localparam logic [7:0]  ADDR_USER_HI   = 8'h87;
  localparam logic [15:0] REG_ROW        = 16'h0080;
  localparam logic [15:0] RESERVED_ROW   = 16'h0088;
  localparam logic [15:0] MEM_LAST       = 16'h008F;
  localparam int          MEM_BYTES      = 144;
  localparam logic [15:0] CRC16_POLY_REF = 16'hA001;
  localparam logic [7:0]  FILL_BYTE      = 8'hFF;
  localparam logic [7:0]  ALT_BYTE       = 8'hAA;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic [7:0]  ES_RESET       = 8'h20;
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          PROG_TIME_US   = 10000;
  localparam int          PROG_CNT_W     = 24;

  typedef struct packed {
    logic       strobe;
    logic       bit_val;
  } slot_t;

  typedef struct packed {
    logic       copy_accepted_flag;
    logic       rsv6;
    logic       invalid_data_flag;
    logic       rsv4;
    logic       rsv3;
    logic [2:0] ending_byte_offset;
  } es_t;

  typedef enum logic [1:0] {PROT_OPEN, PROT_LOCK, PROT_AND} prot_t;

  typedef enum logic [3:0] {
    ST_WAIT_FN, ST_CMD, ST_WS_ADDR, ST_WS_DATA, ST_WS_CRC, ST_RS_SEND,
    ST_CP_AUTH, ST_PROG, ST_CP_DONE, ST_RM_ADDR, ST_RM_DATA, ST_IGNORE
  } state_t;
endpackage

// ==== hw/eeprom_scratchpad_cmd.sv ====
// Memory function command engine: scratchpad, address registers, copy, read
//
// Overview of operation
// - Ending offset loads start, then offset of last byte written
// - Invalid-data flag set on power loss, short write
// - Status bits 3, 4, 6 read zero
// - Scratchpad write clears copy-accepted flag
// - Copy blocked for non-zero low address bits
// - Address low then high, data at offset
// - Partial or misaligned writes stored, copy blocked
// - Write CRC covers command, address, data
// - At offset seven, inverted CRC returned
// - Protected page keeps memory, EPROM page ANDs
// - Read sends address, status, stored data
// - Inverted CRC after data, then ones
// - Matching valid copy sets flag, writes row
// - After programming, alternating bits until reset
// - Invalid data or protection blocks the copy
// - Read memory sequential to 008Fh, then ones
// - Read memory leaves registers and scratchpad
// - Overdrive only when explicitly placed there
// - All bytes travel least significant bit first
// - Protection 55h locks, AAh selects EPROM mode
// - Copy protection blocks register and locked rows
`timescale 1ns/1ps
module eeprom_scratchpad_cmd
  import eeprom_cmd_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_TIME_US * 1000 / CLK_PERIOD_NS
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        link_reset,
  input  wire logic        function_start,
  input  wire slot_t       slot,
  input  wire logic        power_lost,
  input  wire logic        od_set,
  input  wire logic        od_clear,
  output logic             reply_bit,
  output logic             reply_active,
  output logic             overdrive_flag,
  output logic             prog_busy,
  output logic [7:0]       target_address_low,
  output logic [7:0]       target_address_high,
  output es_t              ending_offset_status
);
  state_t                  state_reg;
  logic [2:0]              bit_cnt_reg;
  logic [7:0]              rx_shift_reg;
  logic [7:0]              tx_shift_reg;
  logic [15:0]             crc_reg;
  logic [15:0]             crc_hold_reg;
  logic [7:0]              ta_low_reg;
  logic [7:0]              ta_high_reg;
  es_t                     es_reg;
  logic [7:0]              sp_reg [8];
  logic [2:0]              ptr_reg;
  logic [2:0]              phase_reg;
  logic [15:0]             raddr_reg;
  logic [1:0]              auth_cnt_reg;
  logic                    auth_ok_reg;
  logic                    reset_seen_reg;
  logic [PROG_CNT_W-1:0]   prog_cnt_reg;
  logic                    od_reg;
  logic [7:0]              mem [MEM_BYTES];

  logic                    byte_done;
  logic [7:0]              rx_byte;
  logic                    tx_active;
  logic                    wire_bit;
  logic [15:0]             crc_next;
  logic                    crc_en;
  logic [15:0]             ta16;
  logic [15:0]             wr_addr;
  logic [7:0]              exist_byte;
  logic [7:0]              stored_byte;
  logic [7:0]              tx_next;
  logic                    auth_match;
  logic                    copy_go;
  logic                    prog_done;
  logic                    crc_latch;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    return (c >> 1) ^ ((c[0] ^ b) ? CRC16_POLY_REF : 16'h0000);
  endfunction

  function automatic logic [7:0] mem_read(input logic [15:0] a);
    return (a <= MEM_LAST) ? mem[a[7:0]] : FILL_BYTE;
  endfunction

  function automatic prot_t prot_of(input logic [15:0] a);
    logic [7:0] pc;
    pc = mem[ADDR_PROT_BASE | {6'd0, a[6:5]}];
    if (a < REG_ROW) begin
      return (pc == PROT_WRITE) ? PROT_LOCK : (pc == PROT_EPROM) ? PROT_AND : PROT_OPEN;
    end else if (a <= {8'h00, ADDR_COPY_PROT}) begin
      return (mem[a[7:0]] == PROT_WRITE || mem[a[7:0]] == PROT_EPROM) ? PROT_LOCK : PROT_OPEN;
    end else if (a == {8'h00, ADDR_FACTORY} || a > {8'h00, ADDR_USER_HI}) begin
      return PROT_LOCK;
    end else begin
      return (mem[ADDR_FACTORY] == FACTORY_LOCK) ? PROT_LOCK : PROT_OPEN;
    end
  endfunction

  function automatic logic copy_protected(input logic [15:0] a);
    logic cp;
    cp = (mem[ADDR_COPY_PROT] == PROT_WRITE) || (mem[ADDR_COPY_PROT] == PROT_EPROM);
    return cp && (a >= REG_ROW || prot_of(a) == PROT_LOCK);
  endfunction

  assign byte_done   = slot.strobe && (bit_cnt_reg == 3'd7) && (state_reg != ST_PROG);
  assign rx_byte     = {slot.bit_val, rx_shift_reg[7:1]};
  assign tx_active   = state_reg inside {ST_WS_CRC, ST_RS_SEND, ST_CP_DONE, ST_RM_DATA};
  assign wire_bit    = tx_active ? tx_shift_reg[0] : slot.bit_val;
  assign crc_next    = crc_step(crc_reg, wire_bit);
  assign crc_en      = (state_reg inside {ST_CMD, ST_WS_ADDR, ST_WS_DATA}) ||
                       (state_reg == ST_RS_SEND && phase_reg <= 3'd3);
  assign ta16        = {ta_high_reg, ta_low_reg};
  assign wr_addr     = {ta16[15:3], ptr_reg};
  assign exist_byte  = mem_read(wr_addr);
  assign prog_done   = prog_cnt_reg == PROG_CNT_W'(PROG_CYCLES - 1);
  assign crc_latch   = byte_done && ((state_reg == ST_WS_DATA && ptr_reg == 3'd7) ||
                       (state_reg == ST_RS_SEND && phase_reg == 3'd3 &&
                        ptr_reg == es_reg.ending_byte_offset));

  always_comb begin
    unique case (prot_of(wr_addr))
      PROT_LOCK: stored_byte = exist_byte;
      PROT_AND:  stored_byte = rx_byte & exist_byte;
      default:   stored_byte = rx_byte;
    endcase
  end

  always_comb begin
    unique case (auth_cnt_reg)
      2'd0:    auth_match = rx_byte == ta_low_reg;
      2'd1:    auth_match = rx_byte == ta_high_reg;
      default: auth_match = rx_byte == es_reg;
    endcase
  end

  assign copy_go = byte_done && state_reg == ST_CP_AUTH && auth_cnt_reg == 2'd2 &&
                   auth_ok_reg && auth_match && ta_low_reg[2:0] == 3'd0 &&
                   ta16 < RESERVED_ROW && !es_reg.invalid_data_flag &&
                   !copy_protected(ta16);

  // Byte to shift out after the current byte boundary
  always_comb begin
    tx_next = FILL_BYTE;
    unique case (state_reg)
      ST_CMD:     tx_next = (rx_byte == CMD_READ_SP) ? ta_low_reg : FILL_BYTE;
      ST_WS_DATA: tx_next = (ptr_reg == 3'd7) ? ~crc_next[7:0] : FILL_BYTE;
      ST_WS_CRC:  tx_next = (phase_reg == 3'd0) ? crc_hold_reg[15:8] : FILL_BYTE;
      ST_RS_SEND: begin
        unique case (phase_reg)
          3'd0: tx_next = ta_high_reg;
          3'd1: tx_next = es_reg;
          3'd2: tx_next = sp_reg[ta_low_reg[2:0]];
          3'd3: tx_next = (ptr_reg == es_reg.ending_byte_offset) ? ~crc_next[7:0]
                        : sp_reg[3'(ptr_reg + 3'd1)];
          3'd4: tx_next = crc_hold_reg[15:8];
          default: tx_next = FILL_BYTE;
        endcase
      end
      ST_CP_DONE: tx_next = ALT_BYTE;
      ST_RM_ADDR: tx_next = (phase_reg == 3'd1) ? mem_read({rx_byte, raddr_reg[7:0]})
                          : FILL_BYTE;
      ST_RM_DATA: tx_next = (raddr_reg >= MEM_LAST) ? FILL_BYTE
                          : mem_read(16'(raddr_reg + 16'd1));
      default:    tx_next = FILL_BYTE;
    endcase
  end

  // Bit framing, least significant bit first
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_reg  <= 3'd0;
      rx_shift_reg <= 8'h00;
      tx_shift_reg <= FILL_BYTE;
    end else if (link_reset || function_start || state_reg == ST_PROG) begin
      bit_cnt_reg  <= 3'd0;
      tx_shift_reg <= (state_reg == ST_PROG) ? ALT_BYTE : FILL_BYTE;
    end else if (slot.strobe) begin
      bit_cnt_reg  <= 3'(bit_cnt_reg + 3'd1);
      rx_shift_reg <= rx_byte;
      tx_shift_reg <= byte_done ? tx_next : {1'b1, tx_shift_reg[7:1]};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      crc_reg      <= 16'h0000;
      crc_hold_reg <= 16'h0000;
    end else if (link_reset || function_start) begin
      crc_reg      <= 16'h0000;
    end else if (slot.strobe && crc_en) begin
      crc_reg      <= crc_next;
      if (crc_latch) begin
        crc_hold_reg <= ~crc_next;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      od_reg <= 1'b0;
    end else if (od_set) begin
      od_reg <= 1'b1;
    end else if (od_clear) begin
      od_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prog_cnt_reg <= '0;
    end else if (state_reg == ST_PROG) begin
      prog_cnt_reg <= PROG_CNT_W'(prog_cnt_reg + 1'b1);
    end else begin
      prog_cnt_reg <= '0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= ERASED_BYTE;
      end
    end else if (copy_go) begin
      for (int j = 0; j < 8; j++) begin
        mem[{ta_low_reg[7:3], 3'(j)}] <= sp_reg[j];
      end
    end
  end

  // Command sequencing and address, status and scratchpad registers
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_reg      <= ST_WAIT_FN;
      ta_low_reg     <= 8'h00;
      ta_high_reg    <= 8'h00;
      es_reg         <= es_t'(ES_RESET);
      ptr_reg        <= 3'd0;
      phase_reg      <= 3'd0;
      raddr_reg      <= 16'h0000;
      auth_cnt_reg   <= 2'd0;
      auth_ok_reg    <= 1'b0;
      reset_seen_reg <= 1'b0;
      for (int k = 0; k < 8; k++) begin
        sp_reg[k] <= 8'h00;
      end
    end else begin
      if (state_reg == ST_PROG) begin
        if (link_reset) begin
          reset_seen_reg <= 1'b1;
        end
        if (prog_done) begin
          state_reg <= (reset_seen_reg || link_reset) ? ST_WAIT_FN : ST_CP_DONE;
        end
      end else if (link_reset) begin
        state_reg <= ST_WAIT_FN;
      end else if (function_start && state_reg == ST_WAIT_FN) begin
        state_reg <= ST_CMD;
      end else if (byte_done) begin
        unique case (state_reg)
          ST_CMD: begin
            phase_reg    <= 3'd0;
            auth_cnt_reg <= 2'd0;
            auth_ok_reg  <= 1'b1;
            unique case (rx_byte)
              CMD_WRITE_SP: state_reg <= ST_WS_ADDR;
              CMD_READ_SP:  state_reg <= ST_RS_SEND;
              CMD_COPY_SP:  state_reg <= ST_CP_AUTH;
              CMD_READ_MEM: state_reg <= ST_RM_ADDR;
              default:      state_reg <= ST_IGNORE;
            endcase
          end
          ST_WS_ADDR: begin
            phase_reg <= 3'd1;
            if (phase_reg == 3'd0) begin
              ta_low_reg <= rx_byte;
            end else begin
              ta_high_reg                  <= rx_byte;
              ptr_reg                      <= ta_low_reg[2:0];
              es_reg.ending_byte_offset    <= ta_low_reg[2:0];
              es_reg.invalid_data_flag     <= 1'b1;
              state_reg                    <= ST_WS_DATA;
            end
          end
          ST_WS_DATA: begin
            sp_reg[ptr_reg]           <= stored_byte;
            es_reg.ending_byte_offset <= ptr_reg;
            es_reg.copy_accepted_flag <= 1'b0;
            phase_reg                 <= 3'd0;
            if (ptr_reg == 3'd7) begin
              es_reg.invalid_data_flag <= 1'b0;
              state_reg                <= ST_WS_CRC;
            end else begin
              ptr_reg <= 3'(ptr_reg + 3'd1);
            end
          end
          ST_WS_CRC: phase_reg <= (phase_reg == 3'd2) ? 3'd2 : 3'(phase_reg + 3'd1);
          ST_RS_SEND: begin
            if (phase_reg == 3'd2) begin
              ptr_reg <= ta_low_reg[2:0];
            end else if (phase_reg == 3'd3 && ptr_reg != es_reg.ending_byte_offset) begin
              ptr_reg <= 3'(ptr_reg + 3'd1);
            end
            if (phase_reg != 3'd6 && !(phase_reg == 3'd3 &&
                ptr_reg != es_reg.ending_byte_offset)) begin
              phase_reg <= 3'(phase_reg + 3'd1);
            end
          end
          ST_CP_AUTH: begin
            auth_cnt_reg <= 2'(auth_cnt_reg + 2'd1);
            auth_ok_reg  <= auth_ok_reg && auth_match;
            if (auth_cnt_reg == 2'd2) begin
              state_reg <= copy_go ? ST_PROG : ST_IGNORE;
              if (copy_go) begin
                es_reg.copy_accepted_flag <= 1'b1;
                reset_seen_reg            <= 1'b0;
              end
            end
          end
          ST_RM_ADDR: begin
            phase_reg <= 3'd1;
            raddr_reg <= {rx_byte, raddr_reg[7:0]};
            if (phase_reg == 3'd0) begin
              raddr_reg <= {8'h00, rx_byte};
            end else begin
              state_reg <= ST_RM_DATA;
            end
          end
          ST_RM_DATA: begin
            if (raddr_reg < MEM_LAST) begin
              raddr_reg <= 16'(raddr_reg + 16'd1);
            end
          end
          default: state_reg <= state_reg;
        endcase
      end
      if (power_lost) begin
        es_reg.invalid_data_flag <= 1'b1;
      end
      es_reg.rsv6 <= 1'b0;
      es_reg.rsv4 <= 1'b0;
      es_reg.rsv3 <= 1'b0;
    end
  end

  assign reply_bit            = tx_active ? tx_shift_reg[0] : 1'b1;
  assign reply_active         = tx_active;
  assign overdrive_flag       = od_reg;
  assign prog_busy            = state_reg == ST_PROG;
  assign target_address_low   = ta_low_reg;
  assign target_address_high  = ta_high_reg;
  assign ending_offset_status = es_reg;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_pf_power_loss: assert property (power_lost |=> es_reg.invalid_data_flag)
    else $error("invalid-data flag not set after power loss");
  a_es_reserved_zero: assert property (es_reg.rsv6 == 1'b0 && es_reg.rsv4 == 1'b0 &&
    es_reg.rsv3 == 1'b0)
    else $error("reserved status bits not zero");
  a_aa_cleared_write: assert property (state_reg == ST_WS_DATA && byte_done
    |=> !es_reg.copy_accepted_flag)
    else $error("copy-accepted flag survived a scratchpad write");
  a_copy_misaligned: assert property (state_reg == ST_CP_AUTH && byte_done &&
    auth_cnt_reg == 2'd2 && ta_low_reg[2:0] != 3'd0 |=> state_reg == ST_IGNORE)
    else $error("misaligned copy not blocked");
  a_ending_loaded: assert property (state_reg == ST_WS_ADDR && byte_done && phase_reg == 3'd1
    |=> es_reg.ending_byte_offset == $past(ta_low_reg[2:0]))
    else $error("ending offset not loaded from address");
  a_crc_cleared: assert property (function_start |=> crc_reg == 16'h0000)
    else $error("CRC not cleared at command start");
  a_prog_quiet_regs: assert property (state_reg == ST_PROG ##1 state_reg == ST_PROG
    |-> $stable(ta_low_reg) && $stable(ta_high_reg) && $stable(ptr_reg))
    else $error("registers changed while programming");
  a_rm_keeps_regs: assert property (state_reg == ST_RM_DATA && $past(state_reg) == ST_RM_DATA
    && !$past(power_lost) |-> $stable(es_reg) && $stable(ta16))
    else $error("read memory disturbed registers");
  a_prog_aa_set: assert property ($rose(prog_busy) |-> es_reg.copy_accepted_flag
    ##1 prog_busy)
    else $error("programming without copy-accepted flag");
  a_od_follows: assert property (od_set |=> overdrive_flag ##0 $past(od_set))
    else $error("overdrive flag not set");
  a_fill_after_crc: assert property (state_reg == ST_RS_SEND && phase_reg == 3'd6
    |-> reply_bit)
    else $error("read slots after CRC not all ones");

  c_write_full: cover property (state_reg == ST_WS_DATA ##1 state_reg == ST_WS_CRC);
  c_read_sp_crc: cover property (state_reg == ST_RS_SEND && phase_reg == 3'd5);
  c_copy_done: cover property (prog_busy ##1 state_reg == ST_CP_DONE);
  c_read_mem: cover property (state_reg == ST_RM_DATA && byte_done);
endmodule // eeprom_scratchpad_cmd

// ==== test/slot_master_model.sv ====
// Behavioural bus master issuing time slots to the memory command block
`timescale 1ns/1ps
module slot_master_model
  import eeprom_cmd_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  reply_bit,
  output slot_t      slot,
  output logic       function_start,
  output logic       link_reset,
  output logic       rx_valid,
  output logic [7:0] rx_byte
);
  initial begin
    slot = '{strobe: 1'b0, bit_val: 1'b1};
    function_start = 1'b0;
    link_reset = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end

  // Reset pulse, then selection done
  task automatic start_fn();
    @(posedge clk_sys);
    link_reset <= 1'b1;
    @(posedge clk_sys);
    link_reset <= 1'b0;
    function_start <= 1'b1;
    @(posedge clk_sys);
    function_start <= 1'b0;
  endtask

  // Released line returns to the pull-up level between slots
  task automatic xfer(input logic [7:0] tx, input logic rd);
    logic [7:0] rx;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      rx[i] = reply_bit;
      @(posedge clk_sys);
      slot <= '{strobe: 1'b1, bit_val: tx[i]};
      @(posedge clk_sys);
      slot <= '{strobe: 1'b0, bit_val: 1'b1};
    end
    rx_byte <= rx;
    rx_valid <= rd;
    @(posedge clk_sys);
    rx_valid <= 1'b0;
  endtask
endmodule // slot_master_model

// ==== test/eeprom_scratchpad_memory_commands_tb_top.sv ====
// Self-checking bench for the scratchpad memory command block
`timescale 1ns/1ps
module eeprom_scratchpad_memory_commands_tb_top;
  import eeprom_cmd_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        power_lost = 1'b0;
  logic        od_set = 1'b0;
  logic        od_clear = 1'b0;
  slot_t       slot;
  logic        function_start, link_reset, rx_valid, reply_bit;
  logic        reply_active, overdrive_flag, prog_busy;
  logic [7:0]  ta_lo, ta_hi, rx_byte;
  es_t         es;
  logic [7:0]  tx [8];
  logic [7:0]  sp [8];
  logic [7:0]  m10 [8];
  logic [7:0]  exp_q [$];
  logic [15:0] crc;
  logic [31:0] lfsr = 32'hb09b_2081;
  int          miscompares = 0;
  int          cmp_count = 0;

  always #50 clk_sys = ~clk_sys;

  eeprom_scratchpad_cmd #(.PROG_CYCLES(20)) i_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .link_reset(link_reset), .function_start(function_start), .slot(slot),
    .power_lost(power_lost), .od_set(od_set), .od_clear(od_clear), .reply_bit(reply_bit),
    .reply_active(reply_active), .overdrive_flag(overdrive_flag), .prog_busy(prog_busy),
    .target_address_low(ta_lo), .target_address_high(ta_hi), .ending_offset_status(es));

  slot_master_model i_master (.clk_sys(clk_sys), .reply_bit(reply_bit), .slot(slot),
    .function_start(function_start), .link_reset(link_reset), .rx_valid(rx_valid),
    .rx_byte(rx_byte));

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ CRC16_POLY_REF : c >> 1;
    return c;
  endfunction

  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) chk(rx_byte, exp_q.pop_front());
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic rand_tx();
    for (int i = 0; i < 8; i++) begin
      lfsr = lfsr_next(lfsr);
      tx[i] = lfsr[7:0];
    end
  endtask

  task automatic wr(input logic [7:0] b);
    crc = crc_byte(crc, b);
    i_master.xfer(b, 1'b0);
  endtask

  task automatic rd(input logic [7:0] e, input logic acc);
    exp_q.push_back(e);
    if (acc) crc = crc_byte(crc, e);
    i_master.xfer(8'hFF, 1'b1);
  endtask

  task automatic rd_crc();
    logic [15:0] c;
    c = crc;
    rd(~c[7:0], 1'b0);
    rd(~c[15:8], 1'b0);
  endtask

  task automatic write_sp(input logic [7:0] a, input int n);
    i_master.start_fn();
    crc = 16'h0000;
    wr(CMD_WRITE_SP);
    wr(a);
    wr(8'h00);
    for (int i = 0; i < n; i++) wr(tx[i]);
  endtask

  task automatic read_sp(input logic [7:0] a, input logic [7:0] e);
    i_master.start_fn();
    crc = 16'h0000;
    wr(CMD_READ_SP);
    rd(a, 1'b1);
    rd(8'h00, 1'b1);
    rd(e, 1'b1);
    for (int i = a[2:0]; i <= e[2:0]; i++) rd(sp[i], 1'b1);
    rd_crc();
    rd(FILL_BYTE, 1'b0);
  endtask

  task automatic copy(input logic [7:0] a, input logic [7:0] e, input logic acc);
    i_master.start_fn();
    wr(CMD_COPY_SP);
    wr(a);
    wr(8'h00);
    wr(e);
    @(negedge clk_sys);
    chk({7'h0, prog_busy}, {7'h0, acc});
    for (int n = 0; n < 40 && prog_busy !== 1'b0; n++) @(negedge clk_sys);
    chk({7'h0, prog_busy}, 8'h00);
    chk({7'h0, reply_active}, {7'h0, acc});
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(negedge clk_sys);
    chk(es, ES_RESET);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      od_set <= (k == 0);
      od_clear <= (k == 1);
      @(posedge clk_sys);
      od_set <= 1'b0;
      od_clear <= 1'b0;
      @(negedge clk_sys);
      chk({7'h0, overdrive_flag}, (k == 0) ? 8'h01 : 8'h00);
    end
    $display("test speed flag done");
    rand_tx();
    sp = tx;
    m10 = tx;
    write_sp(8'h10, 8);
    rd_crc();
    @(negedge clk_sys);
    chk(es, 8'h07);
    read_sp(8'h10, 8'h07);
    copy(8'h10, 8'h07, 1'b1);
    chk(es, 8'h87);
    rd(ALT_BYTE, 1'b0);
    rd(ALT_BYTE, 1'b0);
    $display("test write read copy done");
    i_master.start_fn();
    wr(CMD_READ_MEM);
    wr(8'h0E);
    wr(8'h00);
    rd(ERASED_BYTE, 1'b0);
    rd(ERASED_BYTE, 1'b0);
    for (int i = 0; i < 8; i++) rd(m10[i], 1'b0);
    @(negedge clk_sys);
    chk(es, 8'h87);
    chk(ta_lo, 8'h10);
    chk(ta_hi, 8'h00);
    @(posedge clk_sys);
    power_lost <= 1'b1;
    @(posedge clk_sys);
    power_lost <= 1'b0;
    @(negedge clk_sys);
    chk(es, 8'hA7);
    copy(8'h10, 8'hA7, 1'b0);
    $display("test read memory and power loss done");
    // Page 0 EPROM, page 1 locked, copy protection on
    tx = '{PROT_EPROM, PROT_WRITE, 8'hFF, 8'hFF, PROT_WRITE, 8'hFF, 8'hFF, 8'hFF};
    write_sp(REG_ROW[7:0], 8);
    copy(REG_ROW[7:0], 8'h07, 1'b1);
    rand_tx();
    write_sp(8'h10, 8);
    for (int i = 0; i < 8; i++) sp[i] = m10[i] & tx[i];
    read_sp(8'h10, 8'h07);
    write_sp(8'h20, 8);
    sp = '{default: ERASED_BYTE};
    read_sp(8'h20, 8'h07);
    copy(8'h20, 8'h07, 1'b0);
    chk(es, 8'h07);
    $display("test page protection done");
    tx[0] = 8'hA5;
    tx[1] = 8'h5A;
    write_sp(8'h63, 2);
    @(negedge clk_sys);
    chk(es, 8'h24);
    sp[3] = 8'hA5;
    sp[4] = 8'h5A;
    read_sp(8'h63, 8'h24);
    copy(8'h63, 8'h24, 1'b0);
    chk(es, 8'h24);
    $display("test partial write done");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    stop_test();
  end
endmodule // eeprom_scratchpad_memory_commands_tb_top
